// file: rtl/clk_ctl_pkg.sv
package clk_ctl_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] SEL_OFS = 4'h1;
    localparam logic [3:0] CPU_MULT_OFS = 4'h2;
    localparam logic [3:0] CPU_DIV_OFS = 4'h3;
    localparam logic [3:0] REC_MULT_OFS = 4'h4;
    localparam logic [3:0] REC_DIV_OFS = 4'h5;
    localparam logic [3:0] WD_COUNT_OFS = 4'h6;
    localparam logic [3:0] STATUS_OFS = 4'h7;
    localparam logic [3:0] WD_LIVE_OFS = 4'h8;
    localparam logic [3:0] STRAP_OFS = 4'h9;

    // Control register fields.
    localparam int PROG_EN_BIT = 0;
    localparam int OVERRIDE_BIT = 1;
    localparam int REC_SRC_BIT = 2;
    localparam int WD_ARM_BIT = 3;
    localparam int WD_UNIT_BIT = 4;
    localparam int RST_WD_BIT = 5;
    localparam int RST_FC_BIT = 6;
    localparam int CTRL_W = 7;

    // Status register fields.
    localparam int EXPIRED_BIT = 0;
    localparam int RECOVERY_BIT = 1;
    localparam int COUNTING_BIT = 2;

    // Reset values.
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [7:0] CPU_MULT_RST = 8'h00;
    localparam logic [6:0] CPU_DIV_RST = 7'h00;
    localparam logic [7:0] REC_MULT_RST = 8'h00;
    localparam logic [6:0] REC_DIV_RST = 7'h00;
    localparam logic [4:0] WD_COUNT_RST = 5'h01;

    // Timing.
    localparam int CLK_FREQ_MHZ = 125;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WD_SHORT_UNIT_US = 150000;
    localparam int WD_LONG_UNIT_US = 2500000;
    localparam int WD_SHORT_UNIT_CYCLES = WD_SHORT_UNIT_US * CLK_FREQ_MHZ;
    localparam int WD_LONG_UNIT_CYCLES = WD_LONG_UNIT_US * CLK_FREQ_MHZ;
    localparam int PRESCALE_W = 29;
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 8;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_ARMED = 2'b01,
        WD_COUNT = 2'b11,
        WD_EXPIRED = 2'b10
    } wd_state_t;

endpackage

// file: rtl/wd_link_if.sv
`timescale 1ns/1ps
interface wd_link_if;
    logic run;
    logic unit_long;
    logic tick;
    logic rst_trigger;
    logic rst_active;

    modport ctl (output run, output unit_long, output rst_trigger, input tick, input rst_active);
    modport prescale (input run, input unit_long, output tick);
    modport pulser (input rst_trigger, output rst_active);
endinterface

// file: rtl/wd_prescaler.sv
`timescale 1ns/1ps
module wd_prescaler #(
    parameter int SHORT_CYCLES = clk_ctl_pkg::WD_SHORT_UNIT_CYCLES, // Cycles per short unit
    parameter int LONG_CYCLES = clk_ctl_pkg::WD_LONG_UNIT_CYCLES // Cycles per long unit
) (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Synchronous reset, active high
    wd_link_if.prescale lnk // Run request and tick answer
);
    import clk_ctl_pkg::*;

    logic [PRESCALE_W-1:0] cnt_reg;
    logic [PRESCALE_W-1:0] last;

    assign last = lnk.unit_long ? PRESCALE_W'(LONG_CYCLES - 1) : PRESCALE_W'(SHORT_CYCLES - 1);

    // The interval restarts from zero each time the watchdog starts running.
    always_ff @(posedge i_clk) begin
        if (i_rst || !lnk.run) begin
            cnt_reg <= '0;
            lnk.tick <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= '0;
            lnk.tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            lnk.tick <= 1'b0;
        end
    end
endmodule // wd_prescaler

// file: rtl/reset_pulser.sv
`timescale 1ns/1ps
module reset_pulser (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Synchronous reset, active high
    wd_link_if.pulser lnk // Trigger in, pulse out
);
    import clk_ctl_pkg::*;

    logic [PULSE_W-1:0] left_reg;

    // A trigger during a pulse restarts the full width.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            left_reg <= '0;
            lnk.rst_active <= 1'b0;
        end else if (lnk.rst_trigger) begin
            left_reg <= PULSE_W'(RESET_PULSE_CYCLES - 1);
            lnk.rst_active <= 1'b1;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - 1'b1;
            lnk.rst_active <= 1'b1;
        end else begin
            lnk.rst_active <= 1'b0;
        end
    end
endmodule // reset_pulser

// file: rtl/freq_watchdog_ctl.sv
`timescale 1ns/1ps
// Operation
// - Fixed mode: frequency from latched straps, or select code when override set.
// - Programmable mode: frequency from 8-bit multiplier, 7-bit divider and gear.
// - Programmable mode: gear and output ratio follow straps or select code per override.
// - Writing the CPU multiplier or divider in programmable mode, outside recovery, starts loading a new frequency.
// - On expiry switch to recovery: straps if source is 0, recovery values if 1.
// - Recovery values are 8 and 7 bits; recovery ratio follows override.
// - Writing recovery multiplier or divider during recovery with source 1 starts loading the recovery setting.
// - Disarmed watchdog stops and reloads the programmed time-out.
// - Armed watchdog counts down only after a frequency change.
// - Expired flag reads 1 after expiry; writing 1 clears, 0 ignored.
// - Five-bit time-out count; flag set when running count reaches zero.
// - Unit select 0 gives 150 ms per count, 1 gives 2.5 s.
// - Span 150 ms to 4.65 s or 2.5 s to 77.5 s; count zero unused.
// - Reset pulse on expiry only when reset-on-expiry is enabled.
// - Reset pulse after frequency change only when reset-on-change is enabled.
// - Expiry from a hang produces recovery frequency, and system reset when reset-on-expiry is enabled.
// - Programmable mode covers CPU frequencies 50 to 248 MHz.
// - Programmable mode and override default to 0 after power-on.
// - CPU frequency equals gear times (multiplier+3) over (divider+3).
module freq_watchdog_ctl #(
    parameter int SHORT_UNIT_CYCLES = clk_ctl_pkg::WD_SHORT_UNIT_CYCLES, // 150 ms in cycles
    parameter int LONG_UNIT_CYCLES = clk_ctl_pkg::WD_LONG_UNIT_CYCLES // 2.5 s in cycles
) (
    input wire logic i_clk, // Reference clock, 125 MHz
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic [clk_ctl_pkg::ADDR_W-1:0] i_addr, // Register address
    input wire logic [clk_ctl_pkg::DATA_W-1:0] i_wr_data, // Register write data
    input wire logic i_wr_en, // Write strobe
    input wire logic i_rd_en, // Read strobe
    output logic [clk_ctl_pkg::DATA_W-1:0] o_rd_data, // Read data, cycle after strobe
    input wire logic [4:0] i_strap_frequency_pins, // Frequency strap pins
    output logic o_prog_mode, // Synthesizer uses multiplier and divider
    output logic [4:0] o_freq_code, // Table code for gear and ratios
    output logic [7:0] o_multiplier, // Multiplier value to synthesizer
    output logic [6:0] o_divider, // Divider value to synthesizer
    output logic o_freq_load, // Pulse: load new frequency setting
    output logic o_system_reset, // System reset pulse
    output logic o_watchdog_expired // Level copy of the expired flag
);
    import clk_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode.

    logic [CTRL_W-1:0] ctrl_reg;
    logic [4:0] sel_reg;
    logic [7:0] cpu_mult_reg;
    logic [6:0] cpu_div_reg;
    logic [7:0] rec_mult_reg;
    logic [6:0] rec_div_reg;
    logic [4:0] wd_count_reg;
    logic expired_reg;
    logic recovery_reg;
    logic [4:0] strap_meta_reg;
    logic [4:0] strap_sync_reg;
    logic [4:0] strap_latched_reg;
    logic [1:0] strap_wait_reg;
    logic [4:0] wd_cnt_reg;
    logic [4:0] wd_cnt_next;
    wd_state_t wd_state_reg;
    wd_state_t wd_state_next;
    logic prog_next;
    logic [4:0] code_next;
    logic [7:0] mult_next;
    logic [6:0] div_next;
    logic [4:0] ratio_code;
    logic [4:0] wd_reload;
    logic wr_ctrl;
    logic wr_cpu_freq;
    logic wr_rec_freq;
    logic wr_status;
    logic expiry;
    logic change;
    logic load_next;
    logic cpu_load_req_reg;
    logic rec_load_req_reg;

    wd_link_if lnk ();

    assign wr_ctrl = i_wr_en && (i_addr == CTRL_OFS);
    assign wr_cpu_freq = i_wr_en && (i_addr == CPU_MULT_OFS || i_addr == CPU_DIV_OFS);
    assign wr_rec_freq = i_wr_en && (i_addr == REC_MULT_OFS || i_addr == REC_DIV_OFS);
    assign wr_status = i_wr_en && (i_addr == STATUS_OFS);

    // Programmable mode and override both come out of reset clear.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RST;
            sel_reg <= SEL_RST;
            cpu_mult_reg <= CPU_MULT_RST;
            cpu_div_reg <= CPU_DIV_RST;
            rec_mult_reg <= REC_MULT_RST;
            rec_div_reg <= REC_DIV_RST;
            wd_count_reg <= WD_COUNT_RST;
        end else if (i_wr_en) begin
            unique case (i_addr)
                CTRL_OFS: ctrl_reg <= i_wr_data[CTRL_W-1:0];
                SEL_OFS: sel_reg <= i_wr_data[4:0];
                CPU_MULT_OFS: cpu_mult_reg <= i_wr_data;
                CPU_DIV_OFS: cpu_div_reg <= i_wr_data[6:0];
                REC_MULT_OFS: rec_mult_reg <= i_wr_data;
                REC_DIV_OFS: rec_div_reg <= i_wr_data[6:0];
                WD_COUNT_OFS: wd_count_reg <= i_wr_data[4:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            unique case (i_addr)
                CTRL_OFS: o_rd_data <= {1'b0, ctrl_reg};
                SEL_OFS: o_rd_data <= {3'h0, sel_reg};
                CPU_MULT_OFS: o_rd_data <= cpu_mult_reg;
                CPU_DIV_OFS: o_rd_data <= {1'b0, cpu_div_reg};
                REC_MULT_OFS: o_rd_data <= rec_mult_reg;
                REC_DIV_OFS: o_rd_data <= {1'b0, rec_div_reg};
                WD_COUNT_OFS: o_rd_data <= {3'h0, wd_count_reg};
                STATUS_OFS: o_rd_data <= {5'h00, wd_state_reg == WD_COUNT,
                    recovery_reg, expired_reg};
                WD_LIVE_OFS: o_rd_data <= {3'h0, wd_cnt_reg};
                STRAP_OFS: o_rd_data <= {3'h0, strap_latched_reg};
                default: o_rd_data <= '0;
            endcase
        end else begin
            o_rd_data <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture.

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            strap_meta_reg <= i_strap_frequency_pins;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // Straps are caught once, after the synchroniser has filled with pin values.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            strap_wait_reg <= '0;
            strap_latched_reg <= '0;
        end else if (strap_wait_reg != STRAP_SETTLE) begin
            strap_wait_reg <= strap_wait_reg + 1'b1;
            if (strap_wait_reg == STRAP_SETTLE - 2'h1) begin
                strap_latched_reg <= strap_sync_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective frequency setting.

    assign ratio_code = ctrl_reg[OVERRIDE_BIT] ? sel_reg : strap_latched_reg;

    always_comb begin
        prog_next = ctrl_reg[PROG_EN_BIT];
        code_next = ratio_code;
        mult_next = cpu_mult_reg;
        div_next = cpu_div_reg;
        if (recovery_reg) begin
            if (ctrl_reg[REC_SRC_BIT]) begin
                prog_next = 1'b1;
                code_next = ratio_code;
                mult_next = rec_mult_reg;
                div_next = rec_div_reg;
            end else begin
                prog_next = 1'b0;
                code_next = strap_latched_reg;
            end
        end
    end

    assign change = (prog_next != o_prog_mode) || (code_next != o_freq_code)
        || (prog_next && (mult_next != o_multiplier || div_next != o_divider));

    // A forced load waits one cycle for the written value to reach the outputs, so the
    // synthesizer never loads the stale setting and sees a single load pulse.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cpu_load_req_reg <= 1'b0;
            rec_load_req_reg <= 1'b0;
        end else begin
            cpu_load_req_reg <= wr_cpu_freq && !recovery_reg && ctrl_reg[PROG_EN_BIT];
            rec_load_req_reg <= wr_rec_freq && recovery_reg && ctrl_reg[REC_SRC_BIT];
        end
    end

    // A write of the active values reloads even when nothing differs.
    always_comb begin
        load_next = change;
        if (cpu_load_req_reg) begin
            load_next = 1'b1;
        end
        if (rec_load_req_reg) begin
            load_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prog_mode <= 1'b0;
            o_freq_code <= '0;
            o_multiplier <= CPU_MULT_RST;
            o_divider <= CPU_DIV_RST;
            o_freq_load <= 1'b0;
        end else begin
            o_prog_mode <= prog_next;
            o_freq_code <= code_next;
            o_multiplier <= mult_next;
            o_divider <= div_next;
            o_freq_load <= load_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog.

    // A count of zero is never used, so it is run as one unit.
    assign wd_reload = (wd_count_reg == 5'h00) ? 5'h01 : wd_count_reg;
    assign expiry = (wd_state_reg == WD_COUNT) && lnk.tick && (wd_cnt_reg == 5'h01);

    always_comb begin
        wd_state_next = wd_state_reg;
        wd_cnt_next = wd_cnt_reg;
        unique case (wd_state_reg)
            WD_IDLE: begin
                wd_cnt_next = wd_reload;
                if (ctrl_reg[WD_ARM_BIT] && !expired_reg) begin
                    wd_state_next = WD_ARMED;
                end
            end
            WD_ARMED: begin
                wd_cnt_next = wd_reload;
                if (!ctrl_reg[WD_ARM_BIT]) begin
                    wd_state_next = WD_IDLE;
                end else if (o_freq_load) begin
                    wd_state_next = WD_COUNT;
                end
            end
            WD_COUNT: begin
                if (!ctrl_reg[WD_ARM_BIT]) begin
                    wd_state_next = WD_IDLE;
                    wd_cnt_next = wd_reload;
                end else if (expiry) begin
                    wd_state_next = WD_EXPIRED;
                    wd_cnt_next = 5'h00;
                end else if (lnk.tick) begin
                    wd_cnt_next = wd_cnt_reg - 5'h01;
                end
            end
            WD_EXPIRED: begin
                // Rearming waits for the flag to be cleared, so the recovery change
                // itself cannot start another countdown and a reset loop.
                wd_state_next = WD_IDLE;
                wd_cnt_next = wd_reload;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wd_state_reg <= WD_IDLE;
            wd_cnt_reg <= WD_COUNT_RST;
        end else begin
            wd_state_reg <= wd_state_next;
            wd_cnt_reg <= wd_cnt_next;
        end
    end

    // Setting wins over a clear written in the same cycle.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            expired_reg <= 1'b0;
            o_watchdog_expired <= 1'b0;
        end else begin
            expired_reg <= expiry || (expired_reg
                && !(wr_status && i_wr_data[EXPIRED_BIT]));
            o_watchdog_expired <= expiry || (expired_reg
                && !(wr_status && i_wr_data[EXPIRED_BIT]));
        end
    end

    // Recovery stays in force until software clears the expired flag.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            recovery_reg <= 1'b0;
        end else if (expiry) begin
            recovery_reg <= 1'b1;
        end else if (wr_status && i_wr_data[EXPIRED_BIT]) begin
            recovery_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and reset pulse.

    assign lnk.run = (wd_state_reg == WD_COUNT);
    assign lnk.unit_long = ctrl_reg[WD_UNIT_BIT];
    assign lnk.rst_trigger = (expiry && ctrl_reg[RST_WD_BIT])
        || (o_freq_load && ctrl_reg[RST_FC_BIT]);
    assign o_system_reset = lnk.rst_active;

    wd_prescaler #(
        .SHORT_CYCLES(SHORT_UNIT_CYCLES),
        .LONG_CYCLES(LONG_UNIT_CYCLES)
    ) u_prescaler (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .lnk(lnk.prescale)
    );

    reset_pulser u_pulser (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .lnk(lnk.pulser)
    );

endmodule // freq_watchdog_ctl

// file: testbench/clk_ctl_monitor.sv
`timescale 1ns/1ps
module clk_ctl_monitor #(
    parameter int SHORT_UNIT_CYCLES = 20, // Cycles per short unit
    parameter int LONG_UNIT_CYCLES = 50 // Cycles per long unit
) (
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic [clk_ctl_pkg::ADDR_W-1:0] i_addr, // Address
    input wire logic [clk_ctl_pkg::DATA_W-1:0] i_wr_data, // Write data
    input wire logic i_wr_en, // Write strobe
    input wire logic i_rd_en, // Read strobe
    input wire logic [clk_ctl_pkg::DATA_W-1:0] o_rd_data, // Read data
    input wire logic [4:0] i_strap_frequency_pins, // Straps
    input wire logic o_prog_mode, // Programmable mode
    input wire logic [4:0] o_freq_code, // Table code
    input wire logic [7:0] o_multiplier, // Multiplier
    input wire logic [6:0] o_divider, // Divider
    input wire logic o_freq_load, // Load pulse
    input wire logic o_system_reset, // Reset pulse
    input wire logic o_watchdog_expired // Expired flag
);
    import clk_ctl_pkg::*;
    logic [6:0] ctrl_reg;
    logic [7:0] pulse_cnt_reg;
    logic en_any;
    logic clr_wr;
    assign en_any = ctrl_reg[RST_WD_BIT] | ctrl_reg[RST_FC_BIT];
    assign clr_wr = i_wr_en && i_addr == STATUS_OFS && i_wr_data[EXPIRED_BIT];
    // The control byte is shadowed from bus writes, since it has no port of its own.
    always_ff @(posedge i_clk) begin
        if (i_rst) ctrl_reg <= CTRL_RST;
        else if (i_wr_en && i_addr == CTRL_OFS) ctrl_reg <= i_wr_data[6:0];
    end
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_system_reset) pulse_cnt_reg <= 8'h00;
        else if (pulse_cnt_reg != 8'hff) pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_flag_clear: assert property (
        clr_wr |=> !o_watchdog_expired) else $error("Flag survived a clearing write");
    a_flag_holds: assert property (
        o_watchdog_expired && !clr_wr |=> o_watchdog_expired) else $error("Flag dropped");
    a_recov_load: assert property (
        $rose(o_watchdog_expired) |=> o_freq_load) else $error("No recovery load");
    a_expiry_reset: assert property (
        $rose(o_watchdog_expired) && ctrl_reg[RST_WD_BIT] |-> ##[1:2] o_system_reset)
        else $error("No reset on expiry");
    a_reset_cause: assert property (
        $rose(o_system_reset) |-> en_any || $past(en_any) || $past(en_any, 2))
        else $error("Reset pulse while disabled");
    a_change_reset: assert property (
        o_freq_load && ctrl_reg[RST_FC_BIT] && !o_watchdog_expired |-> ##[0:2] o_system_reset)
        else $error("No reset after change");
    a_pulse_width: assert property (
        $fell(o_system_reset) |-> int'(pulse_cnt_reg) >= RESET_PULSE_CYCLES)
        else $error("Reset pulse too short");
    a_mult_load: assert property (
        i_wr_en && i_addr == CPU_MULT_OFS && ctrl_reg[PROG_EN_BIT] && !o_watchdog_expired
        |=> ##1 o_freq_load && o_multiplier == $past(i_wr_data, 2))
        else $error("Multiplier not loaded");
    a_div_load: assert property (
        i_wr_en && i_addr == CPU_DIV_OFS && ctrl_reg[PROG_EN_BIT] && !o_watchdog_expired
        |=> ##1 o_freq_load && {1'b0, o_divider} == ($past(i_wr_data, 2) & 8'h7f))
        else $error("Divider not loaded");
    a_sel_code: assert property (
        i_wr_en && i_addr == SEL_OFS && ctrl_reg[OVERRIDE_BIT] && !ctrl_reg[PROG_EN_BIT]
        && !o_watchdog_expired |=> ##1 {3'h0, o_freq_code} == ($past(i_wr_data, 2) & 8'h1f))
        else $error("Select code not used");
    c_expiry: cover property ($rose(o_watchdog_expired));
    c_sys_reset: cover property ($rose(o_system_reset));
    c_prog_load: cover property (o_freq_load && o_prog_mode);
endmodule // clk_ctl_monitor

bind freq_watchdog_ctl clk_ctl_monitor #(.SHORT_UNIT_CYCLES(SHORT_UNIT_CYCLES),
    .LONG_UNIT_CYCLES(LONG_UNIT_CYCLES)) mon (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_strap_frequency_pins(i_strap_frequency_pins), .o_prog_mode(o_prog_mode),
    .o_freq_code(o_freq_code), .o_multiplier(o_multiplier), .o_divider(o_divider),
    .o_freq_load(o_freq_load), .o_system_reset(o_system_reset),
    .o_watchdog_expired(o_watchdog_expired));

// file: testbench/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
    input wire logic i_clk, // Clock
    output logic [clk_ctl_pkg::ADDR_W-1:0] o_addr, // Address
    output logic [clk_ctl_pkg::DATA_W-1:0] o_wr_data, // Write data
    output logic o_wr_en, // Write strobe
    output logic o_rd_en, // Read strobe
    input wire logic [clk_ctl_pkg::DATA_W-1:0] i_rd_data // Read data
);
    import clk_ctl_pkg::*;
    initial begin
        o_addr = 4'h0;
        o_wr_data = 8'h00;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
    endtask
    // Both halves go out on back-to-back strobes so a half-updated ratio barely stands.
    task automatic wr_pair(input logic [3:0] a, input logic [7:0] d,
                           input logic [3:0] b, input logic [7:0] e);
        @(posedge i_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_addr <= b;
        o_wr_data <= e;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        #1;
        d = i_rd_data;
    endtask
endmodule // host_bus_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clk_ctl_pkg::*;
    localparam int SHORT_C = 20;
    localparam int LONG_C = 50;
    logic i_clk, i_rst, wr_en, rd_en, prog_mode, freq_load, sys_rst, expired;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, mult, rv;
    logic [6:0] div;
    logic [4:0] straps, freq_code;
    int err_count, n_tests, n;
    host_bus_model host (.i_clk(i_clk), .o_addr(addr), .o_wr_data(wdata), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .i_rd_data(rdata));
    freq_watchdog_ctl #(.SHORT_UNIT_CYCLES(SHORT_C), .LONG_UNIT_CYCLES(LONG_C)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .o_rd_data(rdata), .i_strap_frequency_pins(straps),
        .o_prog_mode(prog_mode), .o_freq_code(freq_code), .o_multiplier(mult),
        .o_divider(div), .o_freq_load(freq_load), .o_system_reset(sys_rst),
        .o_watchdog_expired(expired));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    // Edges until expiry (sel 0) or system reset (sel 1); running out ends the run.
    task automatic wait_hi(input int sel, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge i_clk);
            #1;
            cnt++;
        end while (!((sel == 0) ? expired === 1'b1 : sys_rst === 1'b1) && cnt < lim);
        if (cnt >= lim) begin
            chk("wait bound", 8'h00, 8'h01);
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (6) @(posedge i_clk);
        #1;
        chk("prog mode", {7'h00, prog_mode}, 8'h00);
        chk("strap code", {3'h0, freq_code}, 8'h0d);
        host.wr(4'hf, 8'hff);
        host.rd(CTRL_OFS, rv);
        chk("ctrl reset", rv, 8'h00);
        host.rd(4'hf, rv);
        chk("unmapped read", rv, 8'h00);
    endtask
    task automatic t_override();
        host.wr(CTRL_OFS, 8'h02);
        host.wr(SEL_OFS, 8'h15);
        settle();
        chk("override code", {3'h0, freq_code}, 8'h15);
        host.wr(CTRL_OFS, 8'h00);
        settle();
        chk("strap code back", {3'h0, freq_code}, 8'h0d);
    endtask
    task automatic t_prog();
        host.wr(CTRL_OFS, 8'h42);
        host.wr(CTRL_OFS, 8'h43);
        wait_hi(1, 6, n);
        host.wr_pair(CPU_MULT_OFS, 8'h80, CPU_DIV_OFS, 8'h2d);
        settle();
        chk("prog mode on", {7'h00, prog_mode}, 8'h01);
        chk("multiplier", mult, 8'h80);
        chk("divider", {1'b0, div}, 8'h2d);
        chk("gear code", {3'h0, freq_code}, 8'h15);
        repeat (130) @(posedge i_clk);
    endtask
    task automatic t_watchdog();
        host.wr(CTRL_OFS, 8'h03);
        host.wr(WD_COUNT_OFS, 8'h03);
        host.wr_pair(REC_MULT_OFS, 8'h61, REC_DIV_OFS, 8'h5d);
        host.wr(CTRL_OFS, 8'h2f);
        host.wr(CPU_MULT_OFS, 8'h90);
        wait_hi(0, 200, n);
        chk("short expiry", {7'h00, n >= 3 * SHORT_C && n <= 3 * SHORT_C + 6}, 8'h01);
        settle();
        chk("recovery mult", mult, 8'h61);
        chk("recovery div", {1'b0, div}, 8'h5d);
        chk("recovery code", {3'h0, freq_code}, 8'h15);
        chk("expiry reset", {7'h00, sys_rst}, 8'h01);
        host.rd(STATUS_OFS, rv);
        chk("status", {6'h00, rv[1:0]}, 8'h03);
        host.wr(STATUS_OFS, 8'h00);
        host.rd(STATUS_OFS, rv);
        chk("flag kept", {7'h00, rv[0]}, 8'h01);
        host.wr(CTRL_OFS, 8'h27);
        host.wr(STATUS_OFS, 8'h01);
        settle();
        chk("flag cleared", {7'h00, expired}, 8'h00);
        chk("recovery ended", mult, 8'h90);
        repeat (130) @(posedge i_clk);
    endtask
    task automatic t_disarm();
        host.wr(WD_COUNT_OFS, 8'h02);
        host.wr(CPU_MULT_OFS, 8'ha0);
        repeat (100) @(posedge i_clk);
        #1;
        chk("no expiry", {7'h00, expired}, 8'h00);
        host.rd(WD_LIVE_OFS, rv);
        chk("reloaded count", rv, 8'h02);
    endtask
    task automatic t_long();
        host.wr(WD_COUNT_OFS, 8'h01);
        host.wr(CTRL_OFS, 8'h1b);
        host.rd(STATUS_OFS, rv);
        chk("armed idle", {5'h00, rv[2:0]}, 8'h00);
        host.wr(CTRL_OFS, 8'h1a);
        wait_hi(0, 200, n);
        chk("long expiry", {7'h00, n >= LONG_C && n <= LONG_C + 6}, 8'h01);
        settle();
        chk("strap recovery", {7'h00, prog_mode}, 8'h00);
        chk("strap rec code", {3'h0, freq_code}, 8'h0d);
        chk("no reset", {7'h00, sys_rst}, 8'h00);
    endtask
    initial begin
        i_rst = 1'b1;
        straps = 5'h0d;
        err_count = 0;
        n_tests = 0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_override();
        t_prog();
        t_watchdog();
        t_disarm();
        t_long();
        end_sim();
    end
endmodule // tb_top
